// ---- pkg/mrs_pkg.sv ----
// Package for the mesh route selector: register map, field widths, timing
package mrs_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] ADDR_ROUTING_ENABLE   = 4'h0;
	localparam logic [3:0] ADDR_REROUTE_THRESH   = 4'h1;
	localparam logic [3:0] ADDR_ROUTE_REQ_TMO    = 4'h2;
	localparam logic [3:0] ADDR_HOP_COST         = 4'h3;
	localparam logic [3:0] ADDR_RETX_COUNT       = 4'h4;
	localparam logic [3:0] ADDR_STATUS           = 4'h5;
	localparam logic [3:0] ADDR_ROUTE_ENTRY      = 4'h6;
	localparam logic [3:0] ADDR_DEST_SEL         = 4'h7;
	localparam logic [3:0] ADDR_FAIL_COUNT       = 4'h8;

	localparam logic        RST_ROUTING_ENABLE = 1'h0;
	localparam logic [7:0]  RST_REROUTE_THRESH = 8'h09;
	localparam logic [15:0] RST_ROUTE_REQ_TMO  = 16'h000a;
	localparam logic [7:0]  RST_HOP_COST       = 8'h64;
	localparam logic [7:0]  RST_RETX_COUNT     = 8'h05;

	// ****************************************************************
	// Sizes and timing
	// ****************************************************************
	localparam int DEST_W      = 3;
	localparam int NDEST       = 8;
	localparam int PATH_W      = 8;
	localparam int HOPS_W      = 4;
	localparam int COST_W      = 20;
	localparam int MAX_RETRY   = 3;
	localparam int CLK_HZ      = 20000000;
	localparam int TICK_MS     = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	localparam logic [1:0]        RETRY_LIMIT = 2'h3;
	localparam logic [COST_W-1:0] COST_MAX    = 20'hfffff;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic              valid;
		logic [PATH_W-1:0] path_id;
		logic [HOPS_W-1:0] hops;
		logic [7:0]        rssi;
		logic              last;
	} mrs_reply_t;

	typedef struct packed {
		logic              valid;
		logic [PATH_W-1:0] path_id;
	} mrs_route_t;
endpackage : mrs_pkg

// ---- core/mrs_rssi_cost.sv ----
// Per-hop RSSI magnitude to cost lookup
`timescale 1ns/10ps
module mrs_rssi_cost (
	input  wire logic [7:0] rssi,
	output logic      [5:0] cost
);
	// ****************************************************************
	// Lookup
	// ****************************************************************
	function automatic logic [5:0] mrs_map(input logic [7:0] r);
		logic [5:0] c;
		c = 6'h00;
		if (r >= 8'h64)      c = 6'h32;
		else if (r == 8'h63) c = 6'h31;
		else if (r == 8'h62) c = 6'h2c;
		else if (r == 8'h61) c = 6'h28;
		else if (r == 8'h60) c = 6'h26;
		else if (r == 8'h5f) c = 6'h23;
		else if (r == 8'h5e) c = 6'h20;
		else if (r == 8'h5d) c = 6'h1c;
		else if (r == 8'h5c) c = 6'h1a;
		else if (r >= 8'h58) c = 6'h15;
		else if (r == 8'h57) c = 6'h14;
		else if (r == 8'h56) c = 6'h13;
		else if (r == 8'h55) c = 6'h12;
		else if (r == 8'h54) c = 6'h10;
		else if (r >= 8'h4f) c = r[5:0] - 6'h05;
		else if (r == 8'h4e) c = 6'h09;
		else if (r >= 8'h4c) c = 6'h08;
		else if (r >= 8'h4a) c = 6'h07;
		else if (r >= 8'h48) c = 6'h06;
		else if (r >= 8'h46) c = 6'h05;
		else if (r >= 8'h44) c = 6'h04;
		else if (r >= 8'h41) c = 6'h03;
		else if (r >= 8'h3c) c = 6'h02;
		else if (r >= 8'h37) c = 6'h01;
		return c;
	endfunction : mrs_map

	assign cost = mrs_map(rssi);
endmodule : mrs_rssi_cost

// ---- core/mrs_route_selector.sv ----
// Mesh route selector: failure counting, route request sequencing, cost selection
`timescale 1ns/10ps
module mrs_route_selector #(parameter int TICK_CYCLES = mrs_pkg::TICK_CYCLES) (
	input  wire logic                          core_clk,
	input  wire logic                          rstn,
	input  wire logic [3:0]                    reg_addr,
	input  wire logic [15:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [15:0]                   reg_rdata,
	input  wire logic                          pkt_valid,
	input  wire logic [mrs_pkg::DEST_W-1:0]    pkt_dest,
	output logic                               pkt_taken,
	output logic                               pkt_discard,
	input  wire logic                          tx_done,
	input  wire logic                          tx_acked,
	input  wire mrs_pkg::mrs_reply_t           reply,
	output logic                               tx_allow,
	output logic                               req_start,
	output logic      [mrs_pkg::DEST_W-1:0]    req_dest,
	output mrs_pkg::mrs_route_t                route_out
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum {MRS_IDLE, MRS_ISSUE, MRS_WAIT, MRS_DECIDE} mrs_state_t;

	mrs_state_t                          state_ff;
	mrs_state_t                          nxt_state;
	logic                                en_ff;
	logic [7:0]                          thresh_ff;
	logic [15:0]                         tmo_ff;
	logic [7:0]                          hop_cost_ff;
	logic [7:0]                          retx_ff;
	logic [mrs_pkg::DEST_W-1:0]          dest_sel_ff;
	logic [mrs_pkg::NDEST-1:0]           known_ff;
	logic [mrs_pkg::PATH_W-1:0]          path_ff [mrs_pkg::NDEST];
	logic [7:0]                          fail_ff [mrs_pkg::NDEST];
	logic [mrs_pkg::DEST_W-1:0]          cur_dest_ff;
	logic [1:0]                          retry_ff;
	logic [15:0]                         tick_cnt_ff;
	logic [20:0]                         div_ff;
	logic                                tick_ff;
	logic [mrs_pkg::COST_W-1:0]          acc_ff;
	logic [mrs_pkg::COST_W-1:0]          best_ff;
	logic [mrs_pkg::PATH_W-1:0]          best_path_ff;
	logic                                have_best_ff;
	logic [15:0]                         rdata_ff;
	logic                                taken_ff;
	logic                                discard_ff;
	logic                                tx_allow_ff;
	logic                                req_start_ff;
	mrs_pkg::mrs_route_t                 route_ff;
	logic [5:0]                          hop_rssi_cost;
	logic                                pkt_known;
	logic                                pkt_fire;
	logic                                need_route;
	logic                                fail_evt;
	logic                                ack_evt;
	logic                                hit_thresh;
	logic                                tmo_done;
	logic [mrs_pkg::COST_W-1:0]          first_part;
	logic [mrs_pkg::COST_W-1:0]          acc_sum;
	logic [mrs_pkg::COST_W-1:0]          path_total;
	logic                                new_best;
	logic                                busy;

	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] r, input logic w);
		return w && (a == r);
	endfunction : wr_hit

	// ****************************************************************
	// RSSI cost lookup
	// ****************************************************************
	mrs_rssi_cost u_rssi_cost (
		.rssi (reply.rssi),
		.cost (hop_rssi_cost)
	);

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign busy       = (state_ff != MRS_IDLE);
	assign pkt_known  = known_ff[pkt_dest];
	assign pkt_fire   = pkt_valid && !busy && en_ff && !taken_ff && !discard_ff;
	assign need_route = pkt_fire && !pkt_known;
	assign ack_evt    = tx_done && tx_acked;
	assign fail_evt   = tx_done && !tx_acked;
	assign hit_thresh = fail_evt && en_ff && (fail_ff[cur_dest_ff] + 8'h01 >= thresh_ff);
	assign tmo_done   = tick_ff && (tick_cnt_ff + 16'h0001 >= tmo_ff);
	assign first_part = mrs_pkg::COST_W'(reply.hops) * mrs_pkg::COST_W'(hop_cost_ff);
	assign acc_sum    = acc_ff + mrs_pkg::COST_W'(hop_rssi_cost);
	assign path_total = (acc_ff == '0 ? first_part : '0) + acc_sum;
	assign new_best   = reply.valid && reply.last && (state_ff == MRS_WAIT)
		&& (!have_best_ff || path_total < best_ff);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MRS_IDLE: begin
				if (need_route || hit_thresh)
					nxt_state = MRS_ISSUE;
			end
			MRS_ISSUE: nxt_state = MRS_WAIT;
			MRS_WAIT: begin
				if (tmo_done)
					nxt_state = MRS_DECIDE;
			end
			MRS_DECIDE: begin
				if (!have_best_ff && retry_ff != mrs_pkg::RETRY_LIMIT)
					nxt_state = MRS_ISSUE;
				else
					nxt_state = MRS_IDLE;
			end
			default: nxt_state = MRS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			state_ff <= MRS_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ****************************************************************
	// Tick divider and timeout counter
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_ff      <= '0;
			tick_ff     <= 1'b0;
			tick_cnt_ff <= '0;
		end else begin
			tick_ff <= 1'b0;
			if (state_ff != MRS_WAIT) begin
				div_ff      <= '0;
				tick_cnt_ff <= '0;
			end else if (div_ff == 21'(TICK_CYCLES - 1)) begin
				div_ff  <= '0;
				tick_ff <= 1'b1;
			end else begin
				div_ff <= div_ff + 21'h000001;
			end
			if (tick_ff && state_ff == MRS_WAIT)
				tick_cnt_ff <= tick_cnt_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// Candidate accumulation and best path
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_ff       <= '0;
			best_ff      <= mrs_pkg::COST_MAX;
			best_path_ff <= '0;
			have_best_ff <= 1'b0;
		end else if (state_ff == MRS_ISSUE) begin
			acc_ff       <= '0;
			best_ff      <= mrs_pkg::COST_MAX;
			have_best_ff <= 1'b0;
		end else if (state_ff == MRS_WAIT && reply.valid) begin
			acc_ff <= reply.last ? '0 : path_total;
			if (new_best) begin
				best_ff      <= path_total;
				best_path_ff <= reply.path_id;
				have_best_ff <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Request, retry, routing table
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cur_dest_ff  <= '0;
			retry_ff     <= '0;
			known_ff     <= '0;
			req_start_ff <= 1'b0;
			discard_ff   <= 1'b0;
			taken_ff     <= 1'b0;
			route_ff     <= '0;
		end else begin
			req_start_ff <= (nxt_state == MRS_ISSUE);
			discard_ff   <= 1'b0;
			taken_ff     <= pkt_fire && pkt_known;
			if (pkt_fire)
				cur_dest_ff <= pkt_dest;
			if (pkt_fire && pkt_known)
				route_ff <= '{valid: 1'b1, path_id: path_ff[pkt_dest]};
			if (state_ff == MRS_IDLE)
				retry_ff <= '0;
			if (hit_thresh && state_ff == MRS_IDLE)
				known_ff[cur_dest_ff] <= 1'b0;
			if (state_ff == MRS_DECIDE) begin
				if (have_best_ff)
					known_ff[cur_dest_ff] <= 1'b1;
				else if (retry_ff == mrs_pkg::RETRY_LIMIT)
					discard_ff <= 1'b1;
				else
					retry_ff <= retry_ff + 2'h1;
			end
		end
	end

	generate
		for (genvar i = 0; i < mrs_pkg::NDEST; i++) begin : g_dest
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					path_ff[i] <= '0;
					fail_ff[i] <= '0;
				end else begin
					if (state_ff == MRS_DECIDE && have_best_ff && cur_dest_ff == i)
						path_ff[i] <= best_path_ff;
					if (cur_dest_ff == i && (ack_evt || (state_ff == MRS_DECIDE && have_best_ff)))
						fail_ff[i] <= '0;
					else if (cur_dest_ff == i && fail_evt && fail_ff[i] != 8'hff)
						fail_ff[i] <= fail_ff[i] + 8'h01;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Transmit gate
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tx_allow_ff <= 1'b0;
		else
			tx_allow_ff <= (nxt_state == MRS_IDLE);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_ff       <= mrs_pkg::RST_ROUTING_ENABLE;
			thresh_ff   <= mrs_pkg::RST_REROUTE_THRESH;
			tmo_ff      <= mrs_pkg::RST_ROUTE_REQ_TMO;
			hop_cost_ff <= mrs_pkg::RST_HOP_COST;
			retx_ff     <= mrs_pkg::RST_RETX_COUNT;
			dest_sel_ff <= '0;
		end else begin
			if (wr_hit(reg_addr, mrs_pkg::ADDR_ROUTING_ENABLE, reg_wr))
				en_ff <= reg_wdata[0];
			if (wr_hit(reg_addr, mrs_pkg::ADDR_REROUTE_THRESH, reg_wr) && reg_wdata[7:0] != 8'h00)
				thresh_ff <= reg_wdata[7:0];
			if (wr_hit(reg_addr, mrs_pkg::ADDR_ROUTE_REQ_TMO, reg_wr) && reg_wdata != 16'h0000
				&& reg_wdata <= 16'h2710)
				tmo_ff <= reg_wdata;
			if (wr_hit(reg_addr, mrs_pkg::ADDR_HOP_COST, reg_wr))
				hop_cost_ff <= reg_wdata[7:0];
			if (wr_hit(reg_addr, mrs_pkg::ADDR_RETX_COUNT, reg_wr))
				retx_ff <= reg_wdata[7:0];
			if (wr_hit(reg_addr, mrs_pkg::ADDR_DEST_SEL, reg_wr))
				dest_sel_ff <= reg_wdata[mrs_pkg::DEST_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				mrs_pkg::ADDR_ROUTING_ENABLE: rdata_ff <= {15'h0000, en_ff};
				mrs_pkg::ADDR_REROUTE_THRESH: rdata_ff <= {8'h00, thresh_ff};
				mrs_pkg::ADDR_ROUTE_REQ_TMO:  rdata_ff <= tmo_ff;
				mrs_pkg::ADDR_HOP_COST:       rdata_ff <= {8'h00, hop_cost_ff};
				mrs_pkg::ADDR_RETX_COUNT:     rdata_ff <= {8'h00, retx_ff};
				mrs_pkg::ADDR_STATUS:         rdata_ff <= {6'h00, retry_ff, known_ff};
				mrs_pkg::ADDR_ROUTE_ENTRY:    rdata_ff <= {7'h00, known_ff[dest_sel_ff], path_ff[dest_sel_ff]};
				mrs_pkg::ADDR_DEST_SEL:       rdata_ff <= {13'h0000, dest_sel_ff};
				mrs_pkg::ADDR_FAIL_COUNT:     rdata_ff <= {8'h00, fail_ff[dest_sel_ff]};
				default:                      rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata   = rdata_ff;
	assign pkt_taken   = taken_ff;
	assign pkt_discard = discard_ff;
	assign tx_allow    = tx_allow_ff;
	assign req_start   = req_start_ff;
	assign req_dest    = cur_dest_ff;
	assign route_out   = route_ff;
endmodule : mrs_route_selector

// ---- tb/mrs_route_selector_sva.sv ----
// Assertion checker for the mesh route selector ports
`timescale 1ns/10ps
module mrs_route_selector_sva #(parameter int TICK_CYCLES = mrs_pkg::TICK_CYCLES) (
	input wire logic				core_clk,
	input wire logic				rstn,
	input wire logic [3:0]			reg_addr,
	input wire logic [15:0]			reg_wdata,
	input wire logic				reg_wr,
	input wire logic				reg_rd,
	input wire logic [15:0]			reg_rdata,
	input wire logic				pkt_taken,
	input wire logic				pkt_discard,
	input wire logic				tx_allow,
	input wire logic				req_start,
	input wire mrs_pkg::mrs_route_t	route_out
);
	// ********************
	// Shadow state
	// ********************
	logic			en_ff;
	logic			busy_ff;
	logic [15:0]	tmo_ff;
	logic [1:0]		rq_ff;
	int				cnt_ff;
	int				lim;
	assign lim = int'(tmo_ff) * TICK_CYCLES;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_ff <= 1'h0;
			tmo_ff <= 16'h000a;
			busy_ff <= 1'h0;
			rq_ff <= 2'h0;
			cnt_ff <= 0;
		end else begin
			if (reg_wr && reg_addr == mrs_pkg::ADDR_ROUTING_ENABLE) en_ff <= reg_wdata[0];
			if (reg_wr && reg_addr == mrs_pkg::ADDR_ROUTE_REQ_TMO && reg_wdata != 16'h0000 && reg_wdata <= 16'h2710)
				tmo_ff <= reg_wdata;
			if (req_start) begin
				busy_ff <= 1'h1;
				cnt_ff <= 0;
				rq_ff <= busy_ff ? rq_ff + 2'h1 : 2'h0;
			end else if (tx_allow || pkt_discard) begin
				busy_ff <= 1'h0;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff + 1;
			end
		end
	end
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_halt;
		!tx_allow ##1 !tx_allow [*8];
	endsequence
	sequence s_window_done;
		cnt_ff >= lim - 4;
	endsequence
	routing_off_a: assert property (!en_ff && !$past(en_ff) |-> !pkt_taken)
		else $error("packet taken while routing disabled");
	tx_quiet_a: assert property (req_start |-> s_halt)
		else $error("transmission allowed during route request");
	take_allowed_a: assert property (pkt_taken |-> tx_allow && route_out.valid)
		else $error("packet taken without allowance or route");
	wait_min_a: assert property ((req_start || pkt_discard || tx_allow) && busy_ff |-> s_window_done)
		else $error("request window ended early");
	wait_max_a: assert property (busy_ff |-> cnt_ff <= lim + 12)
		else $error("request not reissued or ended after timeout");
	retry_limit_a: assert property (req_start && busy_ff |-> rq_ff != 2'h3)
		else $error("too many request reissues");
	discard_after_a: assert property (pkt_discard |-> rq_ff == 2'h3 && !pkt_taken)
		else $error("discard without three reissues");
	route_hold_a: assert property (!pkt_taken |-> $stable(route_out))
		else $error("route output changed without a take");
	tmo_read_a: assert property ($past(reg_rd) && $past(reg_addr) == mrs_pkg::ADDR_ROUTE_REQ_TMO |-> reg_rdata == tmo_ff)
		else $error("timeout read back wrong");
endmodule : mrs_route_selector_sva
bind mrs_route_selector mrs_route_selector_sva #(.TICK_CYCLES(TICK_CYCLES)) mrs_route_selector_sva_i (
	.core_clk(core_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pkt_taken(pkt_taken), .pkt_discard(pkt_discard), .tx_allow(tx_allow), .req_start(req_start),
	.route_out(route_out));

// ---- tb/mrs_far_end.sv ----
// Far-end modems: route replies and delivery acknowledgements
`timescale 1ns/10ps
module mrs_far_end #(
	parameter int DLY = 180000
) (
	input wire logic			core_clk,
	input wire logic			rstn,
	input wire logic			req_start,
	input wire logic			answer,
	input wire logic			attempt,
	input wire logic			ack_ok,
	output mrs_pkg::mrs_reply_t	reply,
	output logic				tx_done,
	output logic				tx_acked
);
	// Records {path, hops, rssi}; best path at hop cost 100 sent last
	localparam logic [19:0] REC [7] = '{20'h02228, 20'h02261, 20'h03328, 20'h03348, 20'h03328, 20'h01241, 20'h01258};
	logic		busy_ff;
	logic [2:0]	idx_ff;
	int			wait_ff;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_ff <= 1'h0;
			idx_ff <= 3'h0;
			wait_ff <= 0;
			reply <= '0;
			tx_done <= 1'h0;
			tx_acked <= 1'h0;
		end else begin
			tx_done <= attempt;
			tx_acked <= attempt ? ack_ok : ~tx_acked;
			reply <= {1'h0, ~reply[20:0]};
			if (req_start && answer) begin
				busy_ff <= 1'h1;
				wait_ff <= DLY;
				idx_ff <= 3'h0;
			end else if (busy_ff && wait_ff != 0) begin
				wait_ff <= wait_ff - 1;
			end else if (busy_ff) begin
				reply <= {1'h1, REC[idx_ff], idx_ff == 3'h1 || idx_ff == 3'h4 || idx_ff == 3'h6};
				idx_ff <= idx_ff + 3'h1;
				busy_ff <= idx_ff != 3'h6;
			end
		end
	end
endmodule : mrs_far_end

// ---- tb/mrs_route_selector_tb_top.sv ----
// Testbench for the mesh route selector
`timescale 1ns/10ps
module mrs_route_selector_tb_top;
	logic							core_clk = 1'h0;
	logic							rstn = 1'h0;
	logic [3:0]						reg_addr = 4'h0;
	logic [15:0]					reg_wdata = 16'h0000;
	logic [15:0]					reg_rdata;
	logic							reg_wr = 1'h0;
	logic							reg_rd = 1'h0;
	logic							pkt_valid = 1'h0;
	logic [mrs_pkg::DEST_W-1:0]		pkt_dest = 3'h0;
	logic [mrs_pkg::DEST_W-1:0]		req_dest;
	logic							pkt_taken, pkt_discard, tx_done, tx_acked, tx_allow, req_start;
	logic							answer = 1'h1;
	logic							attempt = 1'h0;
	logic							ack_ok = 1'h0;
	mrs_pkg::mrs_reply_t			reply;
	mrs_pkg::mrs_route_t			route_out;
	logic [1:0]						got;
	int								bad_count = 0, checks_done = 0, cyc = 0, nreq, ncyc;
	// Short tick keeps the run small
	localparam int					SIM_TICK = 500;
	always #25 core_clk = ~core_clk;
	mrs_route_selector #(.TICK_CYCLES(SIM_TICK)) mrs_route_selector_i (.core_clk(core_clk), .rstn(rstn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
		.pkt_dest(pkt_dest), .pkt_taken(pkt_taken), .pkt_discard(pkt_discard), .tx_done(tx_done),
		.tx_acked(tx_acked), .reply(reply), .tx_allow(tx_allow), .req_start(req_start), .req_dest(req_dest),
		.route_out(route_out));
	mrs_far_end #(.DLY(SIM_TICK - 100)) mrs_far_end_i (.core_clk(core_clk), .rstn(rstn), .req_start(req_start),
		.answer(answer), .attempt(attempt), .ack_ok(ack_ok), .reply(reply), .tx_done(tx_done),
		.tx_acked(tx_acked));
	// ********************
	// Bus and check tasks
	// ********************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask : rd
	task automatic pkt_run(input logic [2:0] d);
		nreq = 0;
		ncyc = 0;
		@(posedge core_clk);
		pkt_valid <= 1'h1;
		pkt_dest <= d;
		do begin
			@(negedge core_clk);
			ncyc++;
			if (req_start === 1'h1) nreq++;
			got = {pkt_taken, pkt_discard};
		end while (got === 2'h0 && ncyc < 10000);
		@(posedge core_clk);
		pkt_valid <= 1'h0;
	endtask : pkt_run
	task automatic fail_probe(input logic ok, input logic exp);
		logic seen;
		seen = 1'h0;
		@(posedge core_clk);
		attempt <= 1'h1;
		ack_ok <= ok;
		@(posedge core_clk);
		attempt <= 1'h0;
		repeat (6) begin
			@(negedge core_clk);
			if (req_start === 1'h1) seen = 1'h1;
		end
		chk("reroute", seen, exp);
	endtask : fail_probe
	// ********************
	// Scenarios
	// ********************
	task automatic t_regs;
		logic [3:0] a [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
		logic [15:0] e [6] = '{16'h0000, 16'h0009, 16'h000a, 16'h0064, 16'h0005, 16'h0000};
		for (int i = 0; i < 6; i++) rd(a[i], e[i]);
		wr(mrs_pkg::ADDR_REROUTE_THRESH, 16'h0000);
		rd(mrs_pkg::ADDR_REROUTE_THRESH, 16'h0009);
		wr(mrs_pkg::ADDR_ROUTE_REQ_TMO, 16'h2711);
		rd(mrs_pkg::ADDR_ROUTE_REQ_TMO, 16'h000a);
		wr(mrs_pkg::ADDR_ROUTE_REQ_TMO, 16'h2710);
		rd(mrs_pkg::ADDR_ROUTE_REQ_TMO, 16'h2710);
		wr(mrs_pkg::ADDR_HOP_COST, 16'h00ff);
		rd(mrs_pkg::ADDR_HOP_COST, 16'h00ff);
		$display("test registers done");
	endtask : t_regs
	task automatic t_off;
		@(posedge core_clk);
		pkt_valid <= 1'h1;
		pkt_dest <= 3'h2;
		nreq = 0;
		repeat (40) begin
			@(negedge core_clk);
			if (pkt_taken !== 1'h0 || req_start !== 1'h0) nreq++;
		end
		@(posedge core_clk);
		pkt_valid <= 1'h0;
		chk("activity while off", nreq, 0);
		$display("test disabled done");
	endtask : t_off
	task automatic t_discover;
		wr(mrs_pkg::ADDR_ROUTING_ENABLE, 16'h0001);
		wr(mrs_pkg::ADDR_ROUTE_REQ_TMO, 16'h0001);
		wr(mrs_pkg::ADDR_HOP_COST, 16'h0064);
		pkt_run(3'h2);
		chk("outcome", got, 2'h2);
		chk("requests", nreq, 1);
		chk("full wait", ncyc >= SIM_TICK, 1'h1);
		chk("path", route_out.path_id, 8'h01);
		wr(mrs_pkg::ADDR_DEST_SEL, 16'h0002);
		rd(mrs_pkg::ADDR_ROUTE_ENTRY, 16'h0101);
		pkt_run(3'h2);
		chk("fast take", ncyc <= 3 && nreq == 0, 1'h1);
		$display("test discovery done");
	endtask : t_discover
	task automatic t_fail;
		wr(mrs_pkg::ADDR_RETX_COUNT, 16'h0001);
		wr(mrs_pkg::ADDR_REROUTE_THRESH, 16'h0002);
		wr(mrs_pkg::ADDR_HOP_COST, 16'h000a);
		fail_probe(1'h0, 1'h0);
		rd(mrs_pkg::ADDR_FAIL_COUNT, 16'h0001);
		fail_probe(1'h1, 1'h0);
		rd(mrs_pkg::ADDR_FAIL_COUNT, 16'h0000);
		fail_probe(1'h0, 1'h0);
		pkt_run(3'h2);
		chk("old path", route_out.path_id, 8'h01);
		fail_probe(1'h0, 1'h1);
		for (ncyc = 0; ncyc < 5000 && tx_allow !== 1'h1; ncyc++) @(negedge core_clk);
		pkt_run(3'h2);
		chk("new path", route_out.path_id, 8'h03);
		$display("test failures done");
	endtask : t_fail
	task automatic t_discard;
		@(posedge core_clk);
		answer <= 1'h0;
		pkt_run(3'h5);
		chk("outcome", got, 2'h1);
		chk("requests", nreq, 4);
		chk("retry wait", ncyc >= 4 * SIM_TICK, 1'h1);
		chk("req dest", req_dest, 3'h5);
		$display("test discard done");
	endtask : t_discard
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("ERROR run time expected below limit seen limit");
			tally_and_finish;
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'h1;
		t_regs;
		t_off;
		t_discover;
		t_fail;
		t_discard;
		tally_and_finish;
	end
endmodule : mrs_route_selector_tb_top
